//--- verification/tb.sv
// Self-checking bench for the probe-view, self-check key, revision and aux-pin register group.
// Assumes the Wishbone register offsets of the defines header and a one-cycle ack.
`include "toam_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [7:0] REV = 8'h3c; // Arbitrary value
  logic clock = 0, rst = 1, cyc = 0, stb = 0, we = 0, cmd = 0, minl = 0, adci = 0, adcq = 0;
  logic prod = 0, smclk = 0, txa = 0, rxa = 0, sub = 0;
  logic [1:0] dac = 0, corr = 0;
  logic [9:0] adr = 0;
  logic [31:0] wdat = 0, rdat;
  logic [255:0] buses = 0;
  logic ack, start, armed, nl_rx, nl_thr, p1_o, p1_oe, p2_o, p2_oe;
  logic [7:0] rd, e1, g1, e2, g2;
  int miscompares = 0, num_checks = 0, sel1_m, sel2_m;
  toam_test_observe #(.REVISION(REV)) i_dut (.clock(clock), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .probe_buses(buses), .probe_dac(dac),
    .correlator_signal(corr), .minimum_signal_level(minl), .adc_i_level(adci),
    .adc_q_level(adcq), .production_signal(prod), .secure_module_clock(smclk),
    .transmit_active_indication(txa), .receive_active_indication(rxa),
    .subcarrier_detect(sub), .self_test_command(cmd), .self_test_start(start),
    .self_test_armed(armed), .nonlinear_receive_enable(nl_rx),
    .nonlinear_threshold_mode(nl_thr), .analog_probe_pin_one_o(p1_o),
    .analog_probe_pin_one_oe(p1_oe), .analog_probe_pin_two_o(p2_o),
    .analog_probe_pin_two_oe(p2_oe));
  always #4 clock = ~clock;
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  // Classic single cycle; values read at an edge are those sampled by that edge
  // No limit of its own: a missing ack is caught by the watchdog
  task automatic wb(input logic w, input logic [7:0] off, input logic [7:0] wd);
    @(posedge clock);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= {off, 2'b00};
    wdat <= {24'h0, wd};
    do begin
      @(posedge clock);
    end while (ack !== 1'b1);
    rd = rdat[7:0];
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask
  task automatic give_verdict;
    if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Expected level of an aux pin from its selector code, as {oe, o}
  function automatic logic [1:0] pin_exp(input logic [3:0] c, input int p);
    logic [15:0] v;
    v = {buses[sel2_m*8+sel1_m], sub, rxa, txa, 1'b0, 1'b1, smclk, prod, adci ^ adcq, adcq,
         adci, minl, corr[1], corr[0], dac[p], 1'b0};
    return {c != 4'h0, (c != 4'h0) & v[c]};
  endfunction
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    give_verdict();
  end
  initial begin
    void'($urandom(33));
    repeat (2) @(posedge clock);
    rst <= 0;
    wb(0, `TOAM_OFF_SELF_CHECK, 0); chk("self_check reset", 8'h40, rd);
    wb(0, `TOAM_OFF_AUX_SELECT, 0); chk("aux reset", 8'h00, rd);
    @(posedge clock); chk("oe after reset", 8'h0, {6'h0, p1_oe, p2_oe});
    chk("nonlinear reset", 8'h3, {6'h0, nl_rx, nl_thr});
    wb(1, `TOAM_OFF_REVISION, 8'hff); wb(1, `TOAM_OFF_BUS_VIEW, 8'h00);
    wb(0, `TOAM_OFF_REVISION, 0); chk("revision", REV, rd);
    wb(0, 8'h3f, 0); chk("unmapped read", 8'h00, rd);
    wb(1, `TOAM_OFF_SELF_CHECK, 8'hf9); wb(0, `TOAM_OFF_SELF_CHECK, 0);
    chk("self_check readback", 8'h49, rd);
    @(posedge clock); chk("armed key 1001", 8'h1, {7'h0, armed});
    cmd <= 1; @(posedge clock); cmd <= 0; @(posedge clock);
    chk("start pulse", 8'h1, {7'h0, start}); @(posedge clock);
    chk("start ends", 8'h0, {7'h0, start});
    wb(1, `TOAM_OFF_SELF_CHECK, 8'h08); @(posedge clock);
    chk("key 1000", 8'h0, {5'h0, armed, nl_rx, nl_thr});
    wb(1, `TOAM_OFF_SELF_CHECK, 8'h00); @(posedge clock);
    cmd <= 1; @(posedge clock); cmd <= 0; @(posedge clock);
    chk("disabled self-test", 8'h0, {6'h0, armed, start});
    for (int i = 0; i < 6; i++) begin
      sel2_m = $urandom_range(31);
      buses <= {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
      wb(1, `TOAM_OFF_SEL_TWO, 8'(sel2_m));
      repeat (3) @(posedge clock);
      wb(0, `TOAM_OFF_BUS_VIEW, 0); chk("bus view", buses[sel2_m*8+:8], rd);
      wb(0, `TOAM_OFF_SEL_TWO, 0); chk("select two", 8'(sel2_m), rd);
    end
    for (int c = 0; c < 32; c++) begin
      sel1_m = $urandom_range(7);
      {dac, corr, minl, adci, adcq, prod, smclk, txa, rxa, sub} <= 12'($urandom);
      wb(1, `TOAM_OFF_SEL_ONE, 8'(sel1_m));
      wb(1, `TOAM_OFF_AUX_SELECT, {4'(c), ~4'(c)});
      repeat (5) @(posedge clock);
      e1 = 8'(pin_exp(4'(c), 0));
      g1 = {6'h0, p1_oe, p1_oe & p1_o};
      e2 = 8'(pin_exp(~4'(c), 1));
      g2 = {6'h0, p2_oe, p2_oe & p2_o};
      chk("pin one", e1, g1);
      chk("pin two", e2, g2);
      wb(0, `TOAM_OFF_SEL_ONE, 0); chk("select one", 8'(sel1_m), rd);
      wb(0, `TOAM_OFF_RX_STATUS, 0); chk("rx status", {5'h0, sub, rxa, txa}, rd);
    end
    give_verdict();
  end
endmodule
`default_nettype wire

//--- verilog/toam_defs.svh
// Offsets, field positions, reset values and codes of the probe and aux-pin register group.
// Assumes the Wishbone byte address is the register offset times four.
`ifndef TOAM_DEFS_SVH
`define TOAM_DEFS_SVH
`define TOAM_ADDR_W 8
`define TOAM_OFF_SEL_ONE 8'h31
`define TOAM_OFF_SEL_TWO 8'h32
`define TOAM_OFF_BUS_VIEW 8'h35
`define TOAM_OFF_SELF_CHECK 8'h36
`define TOAM_OFF_REVISION 8'h37
`define TOAM_OFF_AUX_SELECT 8'h38
`define TOAM_OFF_RX_STATUS 8'h40
`define TOAM_RST_SELF_CHECK 8'h40
`define TOAM_RST_AUX_SELECT 8'h00
`define TOAM_RST_SEL 8'h00
`define TOAM_REVISION_VALUE 8'h5a
`define TOAM_BIT_NONLINEAR 6
`define TOAM_KEY_HI 3
`define TOAM_KEY_ARMED 4'h9
`define TOAM_KEY_OFF 4'h0
`define TOAM_BUS_SEL_HI 4
`define TOAM_BIT_SEL_HI 2
`define TOAM_PROBE_BUSES 32
`endif

//--- verilog/toam_pkg.sv
// Types shared by the probe and aux-pin register group.
// Assumes the defines header is included where the codes are compared.
package toam_pkg;
  typedef enum logic [3:0] {
    TOAM_SRC_TRISTATE = 4'h0,
    TOAM_SRC_DAC = 4'h1,
    TOAM_SRC_CORR_ONE = 4'h2,
    TOAM_SRC_CORR_TWO = 4'h3,
    TOAM_SRC_MIN_LEVEL = 4'h4,
    TOAM_SRC_ADC_I = 4'h5,
    TOAM_SRC_ADC_Q = 4'h6,
    TOAM_SRC_ADC_IQ = 4'h7,
    TOAM_SRC_PROD = 4'h8,
    TOAM_SRC_CLOCK = 4'h9,
    TOAM_SRC_HIGH = 4'ha,
    TOAM_SRC_LOW = 4'hb,
    TOAM_SRC_TX_ACTIVE = 4'hc,
    TOAM_SRC_RX_ACTIVE = 4'hd,
    TOAM_SRC_SUBCARRIER = 4'he,
    TOAM_SRC_PROBE_BIT = 4'hf
  } toam_src_t;
endpackage

//--- verilog/toam_test_observe.sv
// Probe-bus view, self-check key, revision and aux-pin source selectors on classic Wishbone.
// Assumes analog probe levels arrive as digital stand-ins; async ones except the module clock are synchronised here.
//
// Decided for this implementation: the Wishbone interface to the registers.
`include "toam_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module toam_test_observe #(
  parameter logic [7:0] REVISION = `TOAM_REVISION_VALUE // Arbitrary value
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [`TOAM_PROBE_BUSES*8-1:0] probe_buses,
  input wire logic [1:0] probe_dac,
  input wire logic [1:0] correlator_signal,
  input wire logic minimum_signal_level,
  input wire logic adc_i_level,
  input wire logic adc_q_level,
  input wire logic production_signal,
  input wire logic secure_module_clock,
  input wire logic transmit_active_indication,
  input wire logic receive_active_indication,
  input wire logic subcarrier_detect,
  input wire logic self_test_command,
  output logic self_test_start,
  output logic self_test_armed,
  output logic nonlinear_receive_enable,
  output logic nonlinear_threshold_mode,
  output logic analog_probe_pin_one_o,
  output logic analog_probe_pin_one_oe,
  output logic analog_probe_pin_two_o,
  output logic analog_probe_pin_two_oe
);
  localparam int NSIG = 9;
  logic [7:0] self_check_reg;
  logic [7:0] aux_select_reg;
  logic [7:0] sel_one_reg;
  logic [7:0] sel_two_reg;
  logic [7:0] bus_view_reg;
  logic [NSIG-1:0] sync1_reg;
  logic [NSIG-1:0] sync2_reg;
  logic [7:0] rd_next;
  logic [7:0] adr;
  logic access;
  logic wr;
  logic pin_one_reg;
  logic pin_one_oe_reg;
  logic pin_two_reg;
  logic pin_two_oe_reg;
  logic pin_one_clk_reg;
  logic pin_two_clk_reg;
  logic [7:0] probe_sel_bus;

  assign adr = wb_adr_i[9:2];
  assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = access && wb_we_i && wb_sel_i[0];

  // Async observation inputs except the module clock pass two flip-flops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {subcarrier_detect, receive_active_indication, transmit_active_indication,
                    production_signal, adc_q_level, adc_i_level, minimum_signal_level,
                    correlator_signal};
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= access;
    end
  end

  // Writable registers; read-only offsets have no write path
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      self_check_reg <= `TOAM_RST_SELF_CHECK;
      aux_select_reg <= `TOAM_RST_AUX_SELECT;
      sel_one_reg <= `TOAM_RST_SEL;
      sel_two_reg <= `TOAM_RST_SEL;
    end else if (wr) begin
      case (adr)
        `TOAM_OFF_SELF_CHECK: begin
          self_check_reg <= {1'b0, wb_dat_i[6], 2'b00, wb_dat_i[3:0]};
        end
        `TOAM_OFF_AUX_SELECT: begin
          aux_select_reg <= wb_dat_i[7:0];
        end
        `TOAM_OFF_SEL_ONE: begin
          sel_one_reg <= {5'h00, wb_dat_i[`TOAM_BIT_SEL_HI:0]};
        end
        `TOAM_OFF_SEL_TWO: begin
          sel_two_reg <= {3'h0, wb_dat_i[`TOAM_BUS_SEL_HI:0]};
        end
        default: begin
        end
      endcase
    end
  end

  // Selected probe bus, sampled each cycle
  assign probe_sel_bus = probe_buses[sel_two_reg[`TOAM_BUS_SEL_HI:0]*8 +: 8];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_view_reg <= 8'h00;
    end else begin
      bus_view_reg <= probe_sel_bus;
    end
  end

  always_comb begin
    case (adr)
      `TOAM_OFF_BUS_VIEW: rd_next = bus_view_reg;
      `TOAM_OFF_SELF_CHECK: rd_next = self_check_reg;
      `TOAM_OFF_REVISION: rd_next = REVISION;
      `TOAM_OFF_AUX_SELECT: rd_next = aux_select_reg;
      `TOAM_OFF_SEL_ONE: rd_next = sel_one_reg;
      `TOAM_OFF_SEL_TWO: rd_next = sel_two_reg;
      `TOAM_OFF_RX_STATUS: rd_next = {5'h00, sync2_reg[8:6]};
      default: rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (access && !wb_we_i) begin
      wb_dat_o <= {24'h00_0000, rd_next};
    end
  end

  // Self-test: armed by key, started by command
  assign self_test_armed = (self_check_reg[`TOAM_KEY_HI:0] == `TOAM_KEY_ARMED);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      self_test_start <= 1'b0;
    end else begin
      self_test_start <= self_test_command && self_test_armed;
    end
  end

  assign nonlinear_receive_enable = self_check_reg[`TOAM_BIT_NONLINEAR];
  assign nonlinear_threshold_mode = self_check_reg[`TOAM_BIT_NONLINEAR];

  function automatic logic [1:0] route(input logic [3:0] code, input logic dac,
                                       input logic probe_bit);
    logic [1:0] r;
    r = 2'b01;
    case (toam_pkg::toam_src_t'(code))
      toam_pkg::TOAM_SRC_TRISTATE: r = 2'b00;
      toam_pkg::TOAM_SRC_DAC: r = {dac, 1'b1};
      toam_pkg::TOAM_SRC_CORR_ONE: r = {sync2_reg[0], 1'b1};
      toam_pkg::TOAM_SRC_CORR_TWO: r = {sync2_reg[1], 1'b1};
      toam_pkg::TOAM_SRC_MIN_LEVEL: r = {sync2_reg[2], 1'b1};
      toam_pkg::TOAM_SRC_ADC_I: r = {sync2_reg[3], 1'b1};
      toam_pkg::TOAM_SRC_ADC_Q: r = {sync2_reg[4], 1'b1};
      toam_pkg::TOAM_SRC_ADC_IQ: r = {sync2_reg[3] ^ sync2_reg[4], 1'b1};
      toam_pkg::TOAM_SRC_PROD: r = {sync2_reg[5], 1'b1};
      toam_pkg::TOAM_SRC_CLOCK: r = {secure_module_clock, 1'b1};
      toam_pkg::TOAM_SRC_HIGH: r = 2'b11;
      toam_pkg::TOAM_SRC_LOW: r = 2'b01;
      toam_pkg::TOAM_SRC_TX_ACTIVE: r = {sync2_reg[6], 1'b1};
      toam_pkg::TOAM_SRC_RX_ACTIVE: r = {sync2_reg[7], 1'b1};
      toam_pkg::TOAM_SRC_SUBCARRIER: r = {sync2_reg[8], 1'b1};
      toam_pkg::TOAM_SRC_PROBE_BIT: r = {probe_bit, 1'b1};
      default: r = 2'b00;
    endcase
    return r;
  endfunction

  logic probe_bit;
  assign probe_bit = bus_view_reg[sel_one_reg[`TOAM_BIT_SEL_HI:0]];

  // Pin drivers registered. On the clock code only the mux select is registered, so the
  // clock reaches the pin unsampled and every code switches over on the same edge.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_one_reg <= 1'b0;
      pin_one_oe_reg <= 1'b0;
      pin_two_reg <= 1'b0;
      pin_two_oe_reg <= 1'b0;
      pin_one_clk_reg <= 1'b0;
      pin_two_clk_reg <= 1'b0;
    end else begin
      {pin_one_reg, pin_one_oe_reg} <= route(aux_select_reg[7:4], probe_dac[0], probe_bit);
      {pin_two_reg, pin_two_oe_reg} <= route(aux_select_reg[3:0], probe_dac[1], probe_bit);
      pin_one_clk_reg <= (aux_select_reg[7:4] == toam_pkg::TOAM_SRC_CLOCK);
      pin_two_clk_reg <= (aux_select_reg[3:0] == toam_pkg::TOAM_SRC_CLOCK);
    end
  end

  assign analog_probe_pin_one_o = pin_one_clk_reg ? secure_module_clock : pin_one_reg;
  assign analog_probe_pin_two_o = pin_two_clk_reg ? secure_module_clock : pin_two_reg;
  assign analog_probe_pin_one_oe = pin_one_oe_reg;
  assign analog_probe_pin_two_oe = pin_two_oe_reg;

  a_ack_one_cycle: assert property (@(posedge clock) disable iff (rst)
    wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
  a_key_start: assert property (@(posedge clock) disable iff (rst)
    self_test_start |-> $past(self_check_reg[3:0]) == 4'h9)
    else $error("self-test started without key");
  a_reserved_zero: assert property (@(posedge clock) disable iff (rst)
    self_check_reg[7] == 1'b0 && self_check_reg[5:4] == 2'b00)
    else $error("reserved bits set");
  a_tristate_code: assert property (@(posedge clock) disable iff (rst)
    $past(aux_select_reg[7:4]) == 4'h0 |-> !analog_probe_pin_one_oe)
    else $error("pin one driven while tristate");
  a_high_code: assert property (@(posedge clock) disable iff (rst)
    $past(aux_select_reg[3:0]) == 4'ha |-> analog_probe_pin_two_o && analog_probe_pin_two_oe)
    else $error("pin two not high");
  a_low_code: assert property (@(posedge clock) disable iff (rst)
    $past(aux_select_reg[7:4]) == 4'hb |-> !analog_probe_pin_one_o && analog_probe_pin_one_oe)
    else $error("pin one not low");
  a_ro_write: assert property (@(posedge clock) disable iff (rst)
    wr && adr == `TOAM_OFF_REVISION |=> $stable(aux_select_reg) && $stable(self_check_reg))
    else $error("read-only write changed state");
  a_bus_view: assert property (@(posedge clock) disable iff (rst)
    $stable(probe_sel_bus) |=> bus_view_reg == $past(probe_sel_bus))
    else $error("probe view stale");
  a_nonlinear: assert property (@(posedge clock) disable iff (rst)
    nonlinear_receive_enable == self_check_reg[6] && nonlinear_threshold_mode == self_check_reg[6])
    else $error("non-linear mode mismatch");

  // Steps shared by the properties below
  sequence s_armed_command;
    self_test_command && self_test_armed;
  endsequence
  sequence s_self_check_write;
    wr && adr == `TOAM_OFF_SELF_CHECK;
  endsequence
  sequence s_revision_read;
    access && !wb_we_i && adr == `TOAM_OFF_REVISION;
  endsequence
  a_ack_answer: assert property (@(posedge clock) disable iff (rst)
    access |=> wb_ack_o) else $error("request not answered in the next cycle");
  a_start_on_key: assert property (@(posedge clock) disable iff (rst)
    s_armed_command |=> self_test_start)
    else $error("armed self-test did not start");
  a_nonlinear_write: assert property (@(posedge clock) disable iff (rst)
    s_self_check_write |=> nonlinear_receive_enable == $past(wb_dat_i[`TOAM_BIT_NONLINEAR]))
    else $error("non-linear receive not taken from write");
  a_threshold_write: assert property (@(posedge clock) disable iff (rst)
    s_self_check_write |=> nonlinear_threshold_mode == $past(wb_dat_i[`TOAM_BIT_NONLINEAR]))
    else $error("non-linear threshold mode not taken from write");
  a_revision_read: assert property (@(posedge clock) disable iff (rst)
    s_revision_read |=> wb_dat_o[7:0] == REVISION)
    else $error("revision read wrong value");
  a_view_write: assert property (@(posedge clock) disable iff (rst)
    wr && adr == `TOAM_OFF_BUS_VIEW |=> $stable(self_check_reg) && $stable(aux_select_reg)
      && $stable(sel_one_reg) && $stable(sel_two_reg))
    else $error("probe view write changed state");
  a_bus_select: assert property (@(posedge clock) disable iff (rst)
    wr && adr == `TOAM_OFF_SEL_TWO |=>
      sel_two_reg[`TOAM_BUS_SEL_HI:0] == $past(wb_dat_i[`TOAM_BUS_SEL_HI:0]))
    else $error("probe bus select not stored");
  a_bit_select: assert property (@(posedge clock) disable iff (rst)
    wr && adr == `TOAM_OFF_SEL_ONE |=>
      sel_one_reg[`TOAM_BIT_SEL_HI:0] == $past(wb_dat_i[`TOAM_BIT_SEL_HI:0]))
    else $error("probe bit select not stored");
  a_pin_two_off: assert property (@(posedge clock) disable iff (rst)
    $past(aux_select_reg[3:0]) == 4'h0 |-> !analog_probe_pin_two_oe)
    else $error("pin two driven while tristate");
  a_dac_route: assert property (@(posedge clock) disable iff (rst)
    $past(aux_select_reg[3:0]) == 4'h1 |->
      analog_probe_pin_two_oe && analog_probe_pin_two_o == $past(probe_dac[1]))
    else $error("pin two not showing dac two");
  a_clock_route: assert property (@(posedge clock) disable iff (rst)
    $past(aux_select_reg[7:4]) == 4'h9 |->
      analog_probe_pin_one_oe && analog_probe_pin_one_o == secure_module_clock)
    else $error("pin one not showing module clock");
  a_corr_route: assert property (@(posedge clock) disable iff (rst)
    $past(aux_select_reg[7:4]) == 4'h2 |-> analog_probe_pin_one_o == $past(sync2_reg[0]))
    else $error("pin one not showing correlator one");
  a_tx_route: assert property (@(posedge clock) disable iff (rst)
    $past(aux_select_reg[7:4]) == 4'hc |-> analog_probe_pin_one_o == $past(sync2_reg[6]))
    else $error("pin one not showing transmit active");
  a_rx_route: assert property (@(posedge clock) disable iff (rst)
    $past(aux_select_reg[3:0]) == 4'hd |-> analog_probe_pin_two_o == $past(sync2_reg[7]))
    else $error("pin two not showing receive active");
  a_sub_route: assert property (@(posedge clock) disable iff (rst)
    $past(aux_select_reg[3:0]) == 4'he |-> analog_probe_pin_two_o == $past(sync2_reg[8]))
    else $error("pin two not showing subcarrier detect");
  a_probe_route: assert property (@(posedge clock) disable iff (rst)
    $past(aux_select_reg[7:4]) == 4'hf |->
      analog_probe_pin_one_o == $past(bus_view_reg[sel_one_reg[`TOAM_BIT_SEL_HI:0]]))
    else $error("pin one not showing selected probe bit");
endmodule
`default_nettype wire
